/* File: design/dtc_pkg.sv */
// dual timer/counter package: register indexes, fields, modes, timing
package dtc_pkg;

  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_TL0 = 10'h08a;
  localparam logic [9:0] IDX_TL1 = 10'h08b;
  localparam logic [9:0] IDX_TH0 = 10'h08c;
  localparam logic [9:0] IDX_TH1 = 10'h08d;
  localparam logic [9:0] IDX_AUX_MODE = 10'h08f;
  localparam logic [9:0] IDX_TOGGLE = 10'h090;

  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // timer_mode_select fields
  localparam int MODE_T0_LO = 0;
  localparam int FSEL_T0 = 2;
  localparam int GATE_T0 = 3;
  localparam int MODE_T1_LO = 4;
  localparam int FSEL_T1 = 6;
  localparam int GATE_T1 = 7;
  // timer_aux_mode_select fields
  localparam int MODE2_T0 = 0;
  localparam int MODE2_T1 = 4;
  // control register fields
  localparam int RUN_T0 = 4;
  localparam int FLAG_T0 = 5;
  localparam int RUN_T1 = 6;
  localparam int FLAG_T1 = 7;
  // toggle register fields
  localparam int TOG_T0 = 0;
  localparam int TOG_T1 = 1;

  // machine cycle: processor clocks per machine cycle
  localparam int MC_CLOCKS = 2;
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [7:0] PWM_FORCE_LOW = 8'hff;

  typedef enum logic [2:0] {
    DTC_MODE_13BIT = 3'b000,
    DTC_MODE_16BIT = 3'b001,
    DTC_MODE_AUTO = 3'b010,
    DTC_MODE_SPLIT = 3'b011,
    DTC_MODE_PWM = 3'b110
  } dtc_mode_e;

  // one timer's count bytes plus its overflow event
  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic ovf;
  } dtc_cnt_s;

endpackage : dtc_pkg

/* File: design/dtc_pin_sampler.sv */
// pin synchroniser with once-per-machine-cycle sampling and fall detect
`timescale 1ns/1ns
module dtc_pin_sampler (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // machine cycle strobe
  input wire logic tick,
  // pin in, sampled level and fall pulse out
  input wire logic pin,
  output logic level,
  output logic fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic sample_reg;
  logic fall_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sample_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      if (tick) begin
        sample_reg <= sync2_reg;
      end
      // high then low sample, pulse next clock
      fall_reg <= tick & sample_reg & ~sync2_reg;
    end
  end

  assign level = sync2_reg;
  assign fall = fall_reg;

endmodule : dtc_pin_sampler

/* File: design/dtc_top.sv */
// dual timer/counter core with apb register access
//
// Summary of operation
// - timer function increments the count once per machine cycle (every two clocks) while enabled
// - counter function samples pin each machine cycle, counts high-then-low samples
// - counted edge shows in the count during the following machine cycle
// - edge recognition takes two machine cycles of two clocks each
// - function select bit: clear counts clock, set counts own pin
// - counting needs run set and gate clear or gate pin high; in split, timer 1 ignores run and the high byte ignores gate
// - three mode bits pick 13-bit, 16-bit, auto-reload, split or pwm
// - auto-reload mode reloads low byte from high byte on overflow
// - split mode: low byte timer0, high byte timer on timer1 controls
// - 13-bit mode uses high byte and five low bits only
// - 13-bit mode is an 8-bit counter behind a divide-by-32 prescaler
// - count wrap from all ones to zero sets the overflow flag
// - setting run resumes counting without clearing the count bytes
// - 16-bit mode cascades both full bytes, no prescaler
// - optional pin output inverts on every overflow
// - toggle output starts high, works only in timer function
// - auto-reload leaves the high byte unchanged
// - flag set on overflow, cleared by vectoring or software; pwm drives it
// - pwm period 256 machine cycles (512 clocks), high byte sets the low time
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module dtc_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count input / toggle output pins
  input wire logic first_count_input_pin,
  input wire logic second_count_input_pin,
  output logic [1:0] count_pin_out,
  output logic [1:0] count_pin_oe,
  // gate pins, timer 0 in bit 0
  input wire logic [1:0] gate_input_pin,
  // interrupt vectoring acknowledge and flags
  input wire logic [1:0] vector_ack,
  output logic [1:0] overflow_flag
);

  // next counts for modes 0, 1, 2, 6 and the split low byte
  function automatic dtc_pkg::dtc_cnt_s dtc_step(input logic [2:0] mode,
      input logic [7:0] tl, input logic [7:0] th, input logic inc);
    dtc_pkg::dtc_cnt_s r;
    r.tl = tl;
    r.th = th;
    r.ovf = 1'b0;
    if (inc) begin
      unique case (mode)
        dtc_pkg::DTC_MODE_13BIT: begin
          if (tl[4:0] == dtc_pkg::PRESCALE_LAST) begin
            r.tl = {tl[7:5], 5'h00};
            r.th = th + 8'h01;
            r.ovf = (th == 8'hff);
          end else begin
            r.tl = {tl[7:5], tl[4:0] + 5'h01};
          end
        end
        dtc_pkg::DTC_MODE_16BIT: begin
          {r.th, r.tl} = {th, tl} + 16'h0001;
          r.ovf = ({th, tl} == 16'hffff);
        end
        dtc_pkg::DTC_MODE_AUTO: begin
          r.tl = (tl == 8'hff) ? th : tl + 8'h01;
          r.ovf = (tl == 8'hff);
        end
        dtc_pkg::DTC_MODE_SPLIT, dtc_pkg::DTC_MODE_PWM: begin
          r.tl = tl + 8'h01;
          r.ovf = (tl == 8'hff);
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction : dtc_step

  // pwm flag level: low while count is below the high byte
  function automatic logic dtc_pwm_level(input logic [7:0] tl, input logic [7:0] th);
    return (th != dtc_pkg::PWM_FORCE_LOW) && (tl >= th);
  endfunction : dtc_pwm_level

  logic [7:0] mode_reg;
  logic [7:0] aux_mode_reg;
  logic [1:0] run_reg;
  logic [1:0] flag_reg;
  logic [1:0] toggle_en_reg;
  logic [7:0] tl_reg [2];
  logic [7:0] th_reg [2];
  logic [1:0] pin_out_reg;
  logic [1:0] pin_oe_reg;
  logic [31:0] prdata_reg;
  logic [0:0] mc_phase_reg;

  logic tick;
  logic [1:0] gate_lvl;
  logic [1:0] cnt_fall;
  logic [2:0] mode0;
  logic [2:0] mode1;
  logic [1:0] fsel;
  logic [1:0] gate_en;
  logic split;
  logic [1:0] inc;
  logic th0_inc;
  dtc_pkg::dtc_cnt_s s0;
  dtc_pkg::dtc_cnt_s s1;
  logic th0_ovf;
  logic [1:0] ovf;
  logic [1:0] pwm;
  logic [7:0] tl_next [2];
  logic [7:0] th_next [2];
  logic [1:0] pwm_lvl;
  logic [1:0] hw_set;
  logic [1:0] flag_clr;
  logic [1:0] flag_next;
  logic [1:0] pin_next;

  // machine cycle strobe
  // two clocks per machine cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mc_phase_reg <= 1'b0;
    end else begin
      mc_phase_reg <= mc_phase_reg + 1'b1;
    end
  end
  // peripheral clock tick drives timer function
  assign tick = (mc_phase_reg == 1'((dtc_pkg::MC_CLOCKS) - 1));

  // count pins sampled once per machine cycle
  dtc_pin_sampler u_cnt0 (.clock(clock), .rst(rst), .tick(tick),
    .pin(first_count_input_pin), .level(), .fall(cnt_fall[0]));
  dtc_pin_sampler u_cnt1 (.clock(clock), .rst(rst), .tick(tick),
    .pin(second_count_input_pin), .level(), .fall(cnt_fall[1]));
  dtc_pin_sampler u_gate0 (.clock(clock), .rst(rst), .tick(tick),
    .pin(gate_input_pin[0]), .level(gate_lvl[0]), .fall());
  dtc_pin_sampler u_gate1 (.clock(clock), .rst(rst), .tick(tick),
    .pin(gate_input_pin[1]), .level(gate_lvl[1]), .fall());

  assign mode0 = {aux_mode_reg[dtc_pkg::MODE2_T0], mode_reg[dtc_pkg::MODE_T0_LO +: 2]};
  assign mode1 = {aux_mode_reg[dtc_pkg::MODE2_T1], mode_reg[dtc_pkg::MODE_T1_LO +: 2]};
  assign fsel = {mode_reg[dtc_pkg::FSEL_T1], mode_reg[dtc_pkg::FSEL_T0]};
  assign gate_en = {mode_reg[dtc_pkg::GATE_T1], mode_reg[dtc_pkg::GATE_T0]};
  assign split = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
  assign pwm = {mode1 == dtc_pkg::DTC_MODE_PWM, mode0 == dtc_pkg::DTC_MODE_PWM};

  // run and gate qualify the count source
  // function select picks clock tick or pin edge
  assign inc[0] = run_reg[0] & (~gate_en[0] | gate_lvl[0]) & (fsel[0] ? cnt_fall[0] : tick);
  // timer 1 stopped in its own split mode, free of its run bit while timer 0 splits
  assign inc[1] = (split | run_reg[1]) & (~gate_en[1] | gate_lvl[1])
    & (fsel[1] ? cnt_fall[1] : tick) & (mode1 != dtc_pkg::DTC_MODE_SPLIT);
  // split high byte is a timer on timer 1 run bit
  assign th0_inc = split & run_reg[1] & tick;
  assign th0_ovf = th0_inc & (th_reg[0] == 8'hff);

  assign s0 = dtc_step(mode0, tl_reg[0], th_reg[0], inc[0]);
  assign s1 = dtc_step(mode1, tl_reg[1], th_reg[1], inc[1]);
  assign ovf = {s1.ovf, s0.ovf};

  // apb decode
  logic acc_setup;
  logic acc_write;
  logic [9:0] idx;
  logic aligned;
  logic hit;
  logic [7:0] rd_byte;
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign acc_setup = psel & ~penable;
  assign hit = aligned & (idx == dtc_pkg::IDX_CTRL || idx == dtc_pkg::IDX_MODE
    || idx == dtc_pkg::IDX_TL0 || idx == dtc_pkg::IDX_TL1 || idx == dtc_pkg::IDX_TH0
    || idx == dtc_pkg::IDX_TH1 || idx == dtc_pkg::IDX_AUX_MODE
    || idx == dtc_pkg::IDX_TOGGLE);
  assign acc_write = psel & penable & pwrite & hit;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_aux;
  logic wr_tog;
  logic [1:0] wr_tl;
  logic [1:0] wr_th;
  logic wr_any;
  assign wr_ctrl = acc_write & (idx == dtc_pkg::IDX_CTRL);
  assign wr_mode = acc_write & (idx == dtc_pkg::IDX_MODE);
  assign wr_aux = acc_write & (idx == dtc_pkg::IDX_AUX_MODE);
  assign wr_tog = acc_write & (idx == dtc_pkg::IDX_TOGGLE);
  assign wr_tl = {acc_write & (idx == dtc_pkg::IDX_TL1), acc_write & (idx == dtc_pkg::IDX_TL0)};
  assign wr_th = {acc_write & (idx == dtc_pkg::IDX_TH1), acc_write & (idx == dtc_pkg::IDX_TH0)};
  assign wr_any = acc_write;
  assign rd_byte =
    (idx == dtc_pkg::IDX_CTRL) ? {flag_reg[1], run_reg[1], flag_reg[0], run_reg[0], 4'h0} :
    (idx == dtc_pkg::IDX_MODE) ? mode_reg :
    (idx == dtc_pkg::IDX_TL0) ? tl_reg[0] :
    (idx == dtc_pkg::IDX_TL1) ? tl_reg[1] :
    (idx == dtc_pkg::IDX_TH0) ? th_reg[0] :
    (idx == dtc_pkg::IDX_TH1) ? th_reg[1] :
    (idx == dtc_pkg::IDX_AUX_MODE) ? aux_mode_reg :
    (idx == dtc_pkg::IDX_TOGGLE) ? {6'h00, toggle_en_reg} : 8'h00;

  // software writes win over counting
  assign tl_next[0] = wr_tl[0] ? pwdata[7:0] : s0.tl;
  assign tl_next[1] = wr_tl[1] ? pwdata[7:0] : s1.tl;
  assign th_next[0] = wr_th[0] ? pwdata[7:0] : (th0_inc ? th_reg[0] + 8'h01 : s0.th);
  assign th_next[1] = wr_th[1] ? pwdata[7:0] : s1.th;

  // pwm flag from the 256-count low byte against the high byte
  assign pwm_lvl = {dtc_pwm_level(tl_next[1], th_next[1]), dtc_pwm_level(tl_next[0], th_next[0])};

  // overflow sets the flag; timer 1 flag owned by split high byte
  assign hw_set[0] = ovf[0];
  assign hw_set[1] = split ? th0_ovf : ovf[1];
  // vectoring or a software zero clears; a set in the same cycle wins
  assign flag_clr[0] = vector_ack[0] | (wr_ctrl & ~pwdata[dtc_pkg::FLAG_T0]);
  assign flag_clr[1] = vector_ack[1] | (wr_ctrl & ~pwdata[dtc_pkg::FLAG_T1]);
  assign flag_next = (pwm & pwm_lvl) | (~pwm & (hw_set | (flag_reg & ~flag_clr)));

  // toggle on overflow, high while off or in counter function
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      if (pwm[n]) begin
        pin_next[n] = pwm_lvl[n];
      end else if (!toggle_en_reg[n] || fsel[n]) begin
        pin_next[n] = 1'b1;
      end else begin
        pin_next[n] = pin_out_reg[n] ^ ovf[n];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= dtc_pkg::MODE_RESET;
      aux_mode_reg <= dtc_pkg::MODE_RESET;
      run_reg <= 2'b00;
      toggle_en_reg <= 2'b00;
      flag_reg <= 2'b00;
      pin_out_reg <= 2'b11;
      pin_oe_reg <= 2'b00;
      prdata_reg <= 32'h0000_0000;
    end else begin
      // reserved mode codes are stored as written and hold the count
      if (wr_mode) begin
        mode_reg <= pwdata[7:0];
      end
      if (wr_aux) begin
        aux_mode_reg <= {3'h0, pwdata[dtc_pkg::MODE2_T1], 3'h0, pwdata[dtc_pkg::MODE2_T0]};
      end
      if (wr_ctrl) begin
        run_reg <= {pwdata[dtc_pkg::RUN_T1], pwdata[dtc_pkg::RUN_T0]};
      end
      if (wr_tog) begin
        toggle_en_reg <= {pwdata[dtc_pkg::TOG_T1], pwdata[dtc_pkg::TOG_T0]};
      end
      flag_reg <= flag_next;
      pin_out_reg <= pin_next;
      pin_oe_reg <= pwm | (toggle_en_reg & ~fsel);
      if (acc_setup) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // count bytes change only by counting or writes, never by run
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < 2; n++) begin
        tl_reg[n] <= dtc_pkg::COUNT_RESET;
        th_reg[n] <= dtc_pkg::COUNT_RESET;
      end
    end else begin
      for (int n = 0; n < 2; n++) begin
        tl_reg[n] <= tl_next[n];
        th_reg[n] <= th_next[n];
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign count_pin_out = pin_out_reg;
  assign count_pin_oe = pin_oe_reg;
  assign overflow_flag = flag_reg;

  // checks
  default clocking dtc_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_tick_gap;
    !tick ##1 tick;
  endsequence
  sequence s_pin_fall0;
    cnt_fall[0] && inc[0] && mode_reg[dtc_pkg::FSEL_T0] && !wr_any;
  endsequence

  a_timer_tick_count: assert property (
    (inc[0] && mode0 == dtc_pkg::DTC_MODE_16BIT && !wr_any)
    |=> {th_reg[0], tl_reg[0]} == $past({th_reg[0], tl_reg[0]}) + 16'h0001)
    else $error("16-bit count did not advance by one");
  a_fall_only: assert property (
    (mode_reg[dtc_pkg::FSEL_T0] && inc[0]) |-> cnt_fall[0])
    else $error("counter function counted without a pin fall");
  a_edge_visible: assert property (
    (s_pin_fall0 and (mode0 == dtc_pkg::DTC_MODE_16BIT))
    |=> {th_reg[0], tl_reg[0]} != $past({th_reg[0], tl_reg[0]}))
    else $error("counted edge not visible next cycle");
  a_tick_period: assert property (
    tick |=> s_tick_gap)
    else $error("machine cycle is not two clocks");
  a_gate_block: assert property (
    (!run_reg[0] || (gate_en[0] && !gate_lvl[0])) |-> !inc[0])
    else $error("timer 0 counted while disabled");
  a_reload_value: assert property (
    (inc[0] && mode0 == dtc_pkg::DTC_MODE_AUTO && tl_reg[0] == 8'hff && !wr_any)
    |=> tl_reg[0] == $past(th_reg[0]))
    else $error("auto-reload did not load the high byte");
  a_reload_hold: assert property (
    (mode0 == dtc_pkg::DTC_MODE_AUTO && !wr_any) |=> $stable(th_reg[0]))
    else $error("auto-reload changed the high byte");
  a_split_stop: assert property (
    (mode1 == dtc_pkg::DTC_MODE_SPLIT && !wr_any) |=> $stable(tl_reg[1]) && $stable(th_reg[1]))
    else $error("timer 1 moved in its split mode");
  a_upper_bits: assert property (
    (mode0 == dtc_pkg::DTC_MODE_13BIT && !wr_any) |=> $stable(tl_reg[0][7:5]))
    else $error("13-bit mode touched upper low-byte bits");
  a_prescale: assert property (
    (inc[0] && mode0 == dtc_pkg::DTC_MODE_13BIT && tl_reg[0][4:0] != 5'h1f && !wr_any)
    |=> $stable(th_reg[0]))
    else $error("high byte moved before prescaler wrapped");
  a_overflow_flag: assert property (
    (ovf[0] && !pwm[0]) |=> flag_reg[0])
    else $error("overflow did not set flag");
  a_run_keeps: assert property (
    $rose(run_reg[0]) |-> tl_reg[0] == $past(tl_reg[0]) && th_reg[0] == $past(th_reg[0]))
    else $error("run start changed the count");
  a_toggle_high: assert property (
    (!pwm[0] && (!toggle_en_reg[0] || fsel[0])) |=> count_pin_out[0])
    else $error("toggle output not high while inactive");
  a_ack_clear: assert property (
    (vector_ack[0] && !hw_set[0] && !pwm[0]) |=> !flag_reg[0])
    else $error("vectoring did not clear the flag");
  a_pwm_zero: assert property (
    (pwm[0] && th_reg[0] == 8'h00 && !wr_any) |=> flag_reg[0] && count_pin_out[0])
    else $error("pwm with zero high byte not forced high");

endmodule : dtc_top

/* File: verification/dtc_pin_model.sv */
// far-side model of the count, gate and toggle-output pins
`timescale 1ns/1ns
module dtc_pin_model (
  // clock
  input wire logic clock,
  // design pin side
  input wire logic [1:0] count_pin_out,
  input wire logic [1:0] count_pin_oe,
  output logic first_count_input_pin,
  output logic second_count_input_pin,
  output logic [1:0] gate_input_pin
);
  logic [1:0] drv;

  initial begin
    drv = 2'b11;
    gate_input_pin = 2'b11;
  end

  // the design's driver wins the wire while its enable is high
  assign first_count_input_pin = count_pin_oe[0] ? count_pin_out[0] : drv[0];
  assign second_count_input_pin = count_pin_oe[1] ? count_pin_out[1] : drv[1];

  task automatic set_gate(input logic [1:0] v);
    gate_input_pin <= v;
  endtask : set_gate

  // each level held one machine cycle or more
  task automatic edges(input int idx, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      drv[idx] <= 1'b0;
      repeat (hold) @(posedge clock);
      drv[idx] <= 1'b1;
      repeat (hold) @(posedge clock);
    end
  endtask : edges
endmodule : dtc_pin_model

/* File: verification/tb.sv */
// self-checking bench for the dual timer/counter core
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin0;
  logic pin1;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] gate;
  logic [1:0] vector_ack = 2'b00;
  logic [1:0] overflow_flag;
  int n_mismatch = 0;
  int checks_done = 0;
  int sh[int];
  logic [31:0] q;
  logic e;
  int n;
  int cnt;

  always #2 clock = ~clock;

  dtc_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_count_input_pin(pin0), .second_count_input_pin(pin1), .count_pin_out(pin_out),
    .count_pin_oe(pin_oe), .gate_input_pin(gate), .vector_ack(vector_ack),
    .overflow_flag(overflow_flag));

  dtc_pin_model pm (.clock(clock), .count_pin_out(pin_out), .count_pin_oe(pin_oe),
    .first_count_input_pin(pin0), .second_count_input_pin(pin1), .gate_input_pin(gate));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic load(input logic [7:0] m, input int t, input logic [7:0] tl,
                      input logic [7:0] th);
    apb(1'b1, dtc_pkg::IDX_MODE, m);
    apb(1'b1, dtc_pkg::IDX_TL0 + 10'(t), tl);
    apb(1'b1, dtc_pkg::IDX_TH0 + 10'(t), th);
  endtask : load

  task automatic run_for(input logic [7:0] c, input int clks);
    apb(1'b1, dtc_pkg::IDX_CTRL, c);
    repeat (clks) @(posedge clock);
  endtask : run_for

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    void'($urandom(82));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("pin out reset", 32'(pin_out), 32'h3);
    chk("flag reset", 32'(overflow_flag), 32'h0);
    apb(1'b0, dtc_pkg::IDX_MODE, 8'h00);
    chk("mode reset", q, 32'(dtc_pkg::MODE_RESET));
    apb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped error", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    sh[dtc_pkg::IDX_TH1] = $urandom % 256;
    apb(1'b1, dtc_pkg::IDX_TH1, 8'(sh[dtc_pkg::IDX_TH1]));
    apb(1'b0, dtc_pkg::IDX_TH1, 8'h00);
    chk("count high rw", q, 32'(sh[dtc_pkg::IDX_TH1]));
    load(8'h00, 0, 8'h1e, 8'h00);
    run_for(8'h10, 20);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    apb(1'b0, dtc_pkg::IDX_TH0, 8'h00);
    chk("13-bit carry", q, 32'h01);
    apb(1'b1, dtc_pkg::IDX_TOGGLE, 8'h01);
    load(8'h01, 0, 8'hf8, 8'hff);
    chk("toggle idle", 32'(pin_out[0]), 32'h1);
    chk("toggle drives", 32'(pin_oe), 32'h1);
    run_for(8'h10, 24);
    chk("wrap flag", 32'(overflow_flag[0]), 32'h1);
    chk("toggled", 32'(pin_out[0]), 32'h0);
    vector_ack <= 2'b01;
    @(posedge clock);
    vector_ack <= 2'b00;
    repeat (2) @(posedge clock);
    chk("vector clear", 32'(overflow_flag[0]), 32'h0);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    apb(1'b1, dtc_pkg::IDX_TOGGLE, 8'h00);
    apb(1'b0, dtc_pkg::IDX_TH0, 8'h00);
    chk("16-bit wrap", q, 32'h00);
    load(8'h02, 0, 8'hfc, 8'hf0);
    run_for(8'h10, 24);
    chk("reload flag", 32'(overflow_flag[0]), 32'h1);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    chk("software clear", 32'(overflow_flag[0]), 32'h0);
    apb(1'b0, dtc_pkg::IDX_TL0, 8'h00);
    chk("reloaded low", 32'(q[7:4]), 32'hf);
    apb(1'b0, dtc_pkg::IDX_TH0, 8'h00);
    chk("reload kept", q, 32'hf0);
    // split high byte starts near the top so it wraps and sets the second flag
    load(8'h03, 0, 8'h00, 8'hf8);
    run_for(8'h40, 24);
    chk("split high flag", 32'(overflow_flag[1]), 32'h1);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    apb(1'b0, dtc_pkg::IDX_TL0, 8'h00);
    chk("split low idle", q, 32'h00);
    apb(1'b0, dtc_pkg::IDX_TH0, 8'h00);
    chk("split high runs", 32'(q[7:0] != 8'h00), 32'h1);
    // timer 1 in its own split mode stays stopped although run is set
    load(8'h30, 1, 8'h55, 8'h00);
    run_for(8'h40, 16);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    apb(1'b0, dtc_pkg::IDX_TL1, 8'h00);
    chk("timer 1 stopped", q, 32'h55);
    pm.set_gate(2'b00);
    load(8'h09, 0, 8'h00, 8'h00);
    run_for(8'h10, 24);
    apb(1'b0, dtc_pkg::IDX_TL0, 8'h00);
    chk("gated off", q, 32'h00);
    pm.set_gate(2'b11);
    repeat (24) @(posedge clock);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    apb(1'b0, dtc_pkg::IDX_TL0, 8'h00);
    chk("gated on", 32'(q[7:0] != 8'h00), 32'h1);
    for (int t = 0; t < 2; t++) begin
      n = 3 + $urandom % 6;
      load(t ? 8'h50 : 8'h05, t, 8'h00, 8'h00);
      apb(1'b1, dtc_pkg::IDX_CTRL, t ? 8'h40 : 8'h10);
      pm.edges(t, n, 2 + 2 * t);
      repeat (8) @(posedge clock);
      apb(1'b0, dtc_pkg::IDX_TL0 + 10'(t), 8'h00);
      chk("edge count", q, 32'(n));
    end
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    load(8'h22, 0, 8'h00, 8'h40);
    apb(1'b1, dtc_pkg::IDX_AUX_MODE, 8'hff);
    apb(1'b0, dtc_pkg::IDX_AUX_MODE, 8'h00);
    chk("aux bits", q, 32'h11);
    run_for(8'h10, 8);
    cnt = 0;
    repeat (512) begin
      @(posedge clock);
      if (overflow_flag[0] === 1'b1) cnt++;
    end
    chk("pwm high time", 32'(cnt), 32'(2 * (256 - 'h40)));
    // a zero high byte forces the pin high, all ones forces it low
    apb(1'b1, dtc_pkg::IDX_TH0, 8'h00);
    chk("pwm forced high", 32'(pin_out[0]), 32'h1);
    apb(1'b1, dtc_pkg::IDX_TH0, 8'hff);
    chk("pwm forced low", 32'(pin_out[0]), 32'h0);
    apb(1'b1, dtc_pkg::IDX_CTRL, 8'h00);
    end_of_test();
  end
endmodule : tb
